// ---- include/tmr_defines.vh ----
// Register offsets, field positions and reset values of the timer system
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH
`define TMR_ADDR_W        5
`define TMR_OFF_MODE01    5'h00
`define TMR_OFF_CTRL      5'h01
`define TMR_OFF_T0LO      5'h02
`define TMR_OFF_T0HI      5'h03
`define TMR_OFF_T1LO      5'h04
`define TMR_OFF_T1HI      5'h05
`define TMR_OFF_T2LO      5'h06
`define TMR_OFF_T2HI      5'h07
`define TMR_OFF_RLDLO     5'h08
`define TMR_OFF_RLDHI     5'h09
`define TMR_OFF_CC0LO     5'h0A
`define TMR_OFF_CC3HI     5'h11
`define TMR_OFF_CCMODE    5'h12
`define TMR_OFF_STATUS    5'h13
`define TMR_OFF_MASK      5'h14
`define TMR_OFF_CMPOUT    5'h15
// MODE01 fields
`define TMR_M0_LSB        0
`define TMR_M0_CNT        2
`define TMR_M0_GATE       3
`define TMR_M1_LSB        4
`define TMR_M1_CNT        6
`define TMR_M1_GATE       7
// CTRL fields
`define TMR_C_RUN0        0
`define TMR_C_RUN1        1
`define TMR_C_RUN0HI      2
`define TMR_C_T2SEL_LSB   3
`define TMR_C_PRESC       5
`define TMR_C_RLDMODE     6
`define TMR_C_RLDEN       7
// Timer 0/1 modes
`define TMR_MODE_13       2'd0
`define TMR_MODE_16       2'd1
`define TMR_MODE_AUTO8    2'd2
`define TMR_MODE_SPLIT    2'd3
// Third timer input selection
`define TMR_T2_STOP       2'd0
`define TMR_T2_TIMER      2'd1
`define TMR_T2_EVENT      2'd2
`define TMR_T2_GATED      2'd3
// Compare/capture channel modes
`define TMR_CC_OFF        2'd0
`define TMR_CC_CMP        2'd1
`define TMR_CC_CAPEXT     2'd2
`define TMR_CC_CAPSW      2'd3
// Status bits
`define TMR_S_OVF0        0
`define TMR_S_OVF1        1
`define TMR_S_OVF2        2
`define TMR_S_RLDPIN      3
`define TMR_S_CC_LSB      4
// Pin indexes
`define TMR_PIN_CNT0      0
`define TMR_PIN_CNT1      1
`define TMR_PIN_GATE0     2
`define TMR_PIN_GATE1     3
`define TMR_PIN_CNT2      4
`define TMR_PIN_GATE2     5
`define TMR_PIN_RLD2      6
`define TMR_PIN_CAP_LSB   7
`define TMR_NPINS         11
// Reset values
`define TMR_RST_BYTE      8'h00
`define TMR_RST_WORD      16'h0000
`endif

// ---- design/tmr_pin_sync.v ----
// Three-stage pin synchroniser with filtered level and falling-edge pulse
`timescale 1ns/1ps
module tmr_pin_sync (
    // Clock and reset
    input  wire core_clk,
    input  wire rst,
    // Pin side
    input  wire pinIn,
    // Core side
    output reg  level,
    output reg  fall
);
    reg stage1;
    reg stage2;
    reg stage3;

    always @(posedge core_clk) begin
        if (rst) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
            level  <= 1'b1;
            fall   <= 1'b0;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            // Accept a change once stages two and three agree
            if (stage2 == stage3) begin
                level <= stage3;
                fall  <= level & ~stage3;
            end else begin
                fall  <= 1'b0;
            end
        end
    end
endmodule // tmr_pin_sync

// ---- design/tmr_timer_system.v ----
// Timer system: two general timers, third timer with compare/capture unit
`timescale 1ns/1ps
`include "tmr_defines.vh"

module tmr_timer_system (
    // Clock and reset
    input  wire                   core_clk,
    input  wire                   rst,
    // Register port
    input  wire [`TMR_ADDR_W-1:0] regAddr,
    input  wire [7:0]             regWdata,
    input  wire                   regWr,
    input  wire                   regRd,
    output reg  [7:0]             regRdata,
    // External pins
    input  wire                   firstTimerCountInput,
    input  wire                   secondTimerCountInput,
    input  wire                   firstTimerGate,
    input  wire                   secondTimerGate,
    input  wire                   thirdTimerCountInput,
    input  wire                   thirdTimerGate,
    input  wire                   thirdTimerReloadTriggerInput,
    input  wire [3:0]             captureIn,
    // Outputs
    output reg  [3:0]             compareOut,
    output wire                   irq
);
    reg  [7:0]  modeReg;
    reg  [7:0]  ctrlReg;
    reg  [7:0]  cnt0Lo;
    reg  [7:0]  cnt0Hi;
    reg  [7:0]  cnt1Lo;
    reg  [7:0]  cnt1Hi;
    reg  [15:0] t2;
    reg  [15:0] reloadVal;
    reg  [15:0] cc [0:3];
    reg  [7:0]  ccMode;
    reg  [7:0]  status;
    reg  [7:0]  mask;
    reg         prescTgl;
    reg         t2EventPend;
    wire [`TMR_NPINS-1:0] pinRaw;
    wire [`TMR_NPINS-1:0] pinLevel;
    wire [`TMR_NPINS-1:0] pinFall;

    assign pinRaw = {captureIn, thirdTimerReloadTriggerInput,
                     thirdTimerGate, thirdTimerCountInput,
                     secondTimerGate, firstTimerGate,
                     secondTimerCountInput, firstTimerCountInput};

    // Synchronisers for every external pin
    genvar gi;
    generate
        for (gi = 0; gi < `TMR_NPINS; gi = gi + 1) begin : gSync
            tmr_pin_sync uSync (
                .core_clk (core_clk),
                .rst      (rst),
                .pinIn    (pinRaw[gi]),
                .level    (pinLevel[gi]),
                .fall     (pinFall[gi])
            );
        end
    endgenerate

    // One step of timer 0 or 1: {overflow, high, low}
    function [16:0] stepTimer;
        input [1:0] mode;
        input [7:0] hi;
        input [7:0] lo;
        reg   [13:0] v13;
        reg   [16:0] v16;
        begin
            v13 = {1'b0, hi, lo[4:0]} + 14'h0001;
            v16 = {1'b0, hi, lo} + 17'h0_0001;
            case (mode)
                `TMR_MODE_13:
                    stepTimer = {v13[13], v13[12:5], lo[7:5], v13[4:0]};
                `TMR_MODE_16:
                    stepTimer = v16;
                `TMR_MODE_AUTO8:
                    stepTimer = (&lo) ? {1'b1, hi, hi}
                                      : {1'b0, hi, lo + 8'h01};
                default:
                    stepTimer = {(&lo), hi, lo + 8'h01};
            endcase
        end
    endfunction

    // Timer 0 and 1 count enables
    wire [1:0] mode0 = modeReg[`TMR_M0_LSB+1:`TMR_M0_LSB];
    wire [1:0] mode1 = modeReg[`TMR_M1_LSB+1:`TMR_M1_LSB];
    wire tick0 = modeReg[`TMR_M0_CNT] ? pinFall[`TMR_PIN_CNT0] : 1'b1;
    wire tick1 = modeReg[`TMR_M1_CNT] ? pinFall[`TMR_PIN_CNT1] : 1'b1;
    wire gateOk0 = ~modeReg[`TMR_M0_GATE] | pinLevel[`TMR_PIN_GATE0];
    wire gateOk1 = ~modeReg[`TMR_M1_GATE] | pinLevel[`TMR_PIN_GATE1];
    wire run0 = ctrlReg[`TMR_C_RUN0] & gateOk0 & tick0;
    // Timer 1 stands still in mode 3
    wire run1 = ctrlReg[`TMR_C_RUN1] & gateOk1 & tick1 &
                (mode1 != `TMR_MODE_SPLIT);

    // Split mode: timer 0 high byte runs on its own enable
    wire split0 = (mode0 == `TMR_MODE_SPLIT);
    wire runHi0 = split0 & ctrlReg[`TMR_C_RUN0HI];
    wire [16:0] step0 = stepTimer(mode0, cnt0Hi, cnt0Lo);
    wire [16:0] step1 = stepTimer(mode1, cnt1Hi, cnt1Lo);
    wire [8:0]  hi0Inc = {1'b0, cnt0Hi} + 9'h001;

    // Third timer control
    wire [1:0] t2Sel = ctrlReg[`TMR_C_T2SEL_LSB+1:`TMR_C_T2SEL_LSB];
    wire prescOk = ~ctrlReg[`TMR_C_PRESC] | prescTgl;
    reg  t2Tick;
    always @* begin
        case (t2Sel)
            `TMR_T2_TIMER: t2Tick = prescOk;
            `TMR_T2_EVENT: t2Tick = t2EventPend;
            `TMR_T2_GATED: t2Tick = prescOk & pinLevel[`TMR_PIN_GATE2];
            default:       t2Tick = 1'b0;
        endcase
    end
    wire [16:0] t2Inc = {1'b0, t2} + 17'h0_0001;
    wire t2Ovf = t2Tick & t2Inc[16];
    wire pinReload = ctrlReg[`TMR_C_RLDEN] & ctrlReg[`TMR_C_RLDMODE] &
                     pinFall[`TMR_PIN_RLD2];
    wire ovfReload = ctrlReg[`TMR_C_RLDEN] & ~ctrlReg[`TMR_C_RLDMODE] &
                     t2Ovf;
    reg  [15:0] next_t2;
    always @* begin
        // Reload beats a count
        if (pinReload | ovfReload) begin
            next_t2 = reloadVal;
        end else if (t2Tick) begin
            next_t2 = t2Inc[15:0];
        end else begin
            next_t2 = t2;
        end
    end

    // Compare and capture events per channel
    wire [3:0] ccMatch;
    wire [3:0] ccCapExt;
    wire [3:0] ccCapSw;
    wire [3:0] ccEvent;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : gCc
            wire [1:0] cm = ccMode[2*gi+1:2*gi];
            // Byte address of this channel's low half
            localparam [31:0] LO_FULL = `TMR_OFF_CC0LO + 2 * gi;
            wire [4:0] loAddr = LO_FULL[4:0];
            assign ccMatch[gi] = (cm == `TMR_CC_CMP) &
                                 (t2 == cc[gi]);
            assign ccCapExt[gi] = (cm == `TMR_CC_CAPEXT) &
                                  pinFall[`TMR_PIN_CAP_LSB+gi];
            assign ccCapSw[gi] = (cm == `TMR_CC_CAPSW) & regWr &
                                 (regAddr == loAddr);
            assign ccEvent[gi] = ccMatch[gi] | ccCapExt[gi] | ccCapSw[gi];
            // Compare register: capture, else software write
            always @(posedge core_clk) begin
                if (rst) begin
                    cc[gi] <= `TMR_RST_WORD;
                end else if (ccCapExt[gi] | ccCapSw[gi]) begin
                    cc[gi] <= t2;
                end else if (regWr & (regAddr == loAddr)) begin
                    cc[gi][7:0] <= regWdata;
                end else if (regWr & (regAddr == loAddr + 5'd1)) begin
                    cc[gi][15:8] <= regWdata;
                end
            end
            // Output set on match, cleared when timer 2 wraps or reloads
            always @(posedge core_clk) begin
                if (rst) begin
                    compareOut[gi] <= 1'b0;
                end else if (ccMatch[gi]) begin
                    compareOut[gi] <= 1'b1;
                end else if (t2Ovf | pinReload) begin
                    compareOut[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Status events; set wins over write-one-to-clear
    // Bit 1 shared by timer 1 and split high byte
    wire [7:0] events = {ccEvent, pinReload, t2Ovf,
                         (run1 & step1[16]) | (runHi0 & hi0Inc[8]),
                         run0 & step0[16]};
    wire [7:0] clrMask = (regWr & (regAddr == `TMR_OFF_STATUS)) ?
                         regWdata : 8'h00;
    assign irq = |(status & mask);

    // Control, counters and status
    always @(posedge core_clk) begin
        if (rst) begin
            modeReg     <= `TMR_RST_BYTE;
            ctrlReg     <= `TMR_RST_BYTE;
            cnt0Lo      <= `TMR_RST_BYTE;
            cnt0Hi      <= `TMR_RST_BYTE;
            cnt1Lo      <= `TMR_RST_BYTE;
            cnt1Hi      <= `TMR_RST_BYTE;
            t2          <= `TMR_RST_WORD;
            reloadVal   <= `TMR_RST_WORD;
            ccMode      <= `TMR_RST_BYTE;
            status      <= `TMR_RST_BYTE;
            mask        <= `TMR_RST_BYTE;
            prescTgl    <= 1'b0;
            t2EventPend <= 1'b0;
        end else begin
            prescTgl    <= ~prescTgl;
            // Edge registered, applied one cycle later
            t2EventPend <= pinFall[`TMR_PIN_CNT2];
            status      <= (status & ~clrMask) | events;
            if (run0) begin
                cnt0Lo <= step0[7:0];
                if (!split0) begin
                    cnt0Hi <= step0[15:8];
                end
            end
            if (runHi0) begin
                cnt0Hi <= hi0Inc[7:0];
            end
            if (run1) begin
                cnt1Lo <= step1[7:0];
                cnt1Hi <= step1[15:8];
            end

            t2 <= next_t2;
            // Software write wins over a count in the same cycle
            if (regWr) begin
                case (regAddr)
                    `TMR_OFF_MODE01: modeReg        <= regWdata;
                    `TMR_OFF_CTRL:   ctrlReg        <= regWdata;
                    `TMR_OFF_T0LO:   cnt0Lo         <= regWdata;
                    `TMR_OFF_T0HI:   cnt0Hi         <= regWdata;
                    `TMR_OFF_T1LO:   cnt1Lo         <= regWdata;
                    `TMR_OFF_T1HI:   cnt1Hi         <= regWdata;
                    `TMR_OFF_T2LO:   t2[7:0]        <= regWdata;
                    `TMR_OFF_T2HI:   t2[15:8]       <= regWdata;
                    `TMR_OFF_RLDLO:  reloadVal[7:0] <= regWdata;
                    `TMR_OFF_RLDHI:  reloadVal[15:8] <= regWdata;
                    `TMR_OFF_CCMODE: ccMode         <= regWdata;
                    `TMR_OFF_MASK:   mask           <= regWdata;
                    default: ;
                endcase
            end
        end
    end

    // Read data, one cycle after the strobe
    reg [7:0] next_rdata;
    always @* begin
        case (regAddr)
            `TMR_OFF_MODE01: next_rdata = modeReg;
            `TMR_OFF_CTRL:   next_rdata = ctrlReg;
            `TMR_OFF_T0LO:   next_rdata = cnt0Lo;
            `TMR_OFF_T0HI:   next_rdata = cnt0Hi;
            `TMR_OFF_T1LO:   next_rdata = cnt1Lo;
            `TMR_OFF_T1HI:   next_rdata = cnt1Hi;
            `TMR_OFF_T2LO:   next_rdata = t2[7:0];
            `TMR_OFF_T2HI:   next_rdata = t2[15:8];
            `TMR_OFF_RLDLO:  next_rdata = reloadVal[7:0];
            `TMR_OFF_RLDHI:  next_rdata = reloadVal[15:8];
            5'h0A:           next_rdata = cc[0][7:0];
            5'h0B:           next_rdata = cc[0][15:8];
            5'h0C:           next_rdata = cc[1][7:0];
            5'h0D:           next_rdata = cc[1][15:8];
            5'h0E:           next_rdata = cc[2][7:0];
            5'h0F:           next_rdata = cc[2][15:8];
            5'h10:           next_rdata = cc[3][7:0];
            `TMR_OFF_CC3HI:  next_rdata = cc[3][15:8];
            `TMR_OFF_CCMODE: next_rdata = ccMode;
            `TMR_OFF_STATUS: next_rdata = status;
            `TMR_OFF_MASK:   next_rdata = mask;
            `TMR_OFF_CMPOUT: next_rdata = {4'h0, compareOut};
            default:         next_rdata = 8'h00;
        endcase
    end

    always @(posedge core_clk) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            regRdata <= next_rdata;
        end else begin
            // Data stands one cycle only
            regRdata <= 8'h00;
        end
    end
endmodule // tmr_timer_system

// ---- dv/tmr_timer_system_properties.sv ----
// Port-level assertions of the timer system
`timescale 1ns/1ps
`include "tmr_defines.vh"
module tmr_timer_system_properties (
    // Clock and reset
    input wire                   core_clk,
    input wire                   rst,
    // Register port
    input wire [`TMR_ADDR_W-1:0] regAddr,
    input wire [7:0]             regWdata,
    input wire                   regWr,
    input wire                   regRd,
    input wire [7:0]             regRdata,
    // Outputs
    input wire [3:0]             compareOut,
    input wire                   irq
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_rstOut;
        $fell(rst) |-> !irq && compareOut == 4'h0 && regRdata == 8'h00;
    endproperty
    a_rstOut: assert property (p_rstOut) else $error("reset out");
    property p_idleRd;
        !regRd |=> regRdata == 8'h00;
    endproperty
    a_idleRd: assert property (p_idleRd) else $error("idle rdata");
    property p_unmap;
        regRd && regAddr > `TMR_OFF_CMPOUT |=> regRdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_cmpRd;
        regRd && regAddr == `TMR_OFF_CMPOUT
            |=> regRdata == {4'h0, $past(compareOut)};
    endproperty
    a_cmpRd: assert property (p_cmpRd) else $error("cmp read");
    property p_irqFall;
        $fell(irq) |-> $past(regWr) && ($past(regAddr) == `TMR_OFF_STATUS
            || $past(regAddr) == `TMR_OFF_MASK);
    endproperty
    a_irqFall: assert property (p_irqFall) else $error("irq fall");
    property p_mask0;
        regWr && regAddr == `TMR_OFF_MASK && regWdata == 8'h00 |=> !irq;
    endproperty
    a_mask0: assert property (p_mask0) else $error("mask zero");
    property p_maskRb;
        regWr && regAddr == `TMR_OFF_MASK ##1 !regWr ##1
            regRd && regAddr == `TMR_OFF_MASK
            |=> regRdata == $past(regWdata, 3);
    endproperty
    a_maskRb: assert property (p_maskRb) else $error("mask read");
    property p_rldRb;
        regWr && regAddr == `TMR_OFF_RLDHI ##1 !regWr ##1
            regRd && regAddr == `TMR_OFF_RLDHI
            |=> regRdata == $past(regWdata, 3);
    endproperty
    a_rldRb: assert property (p_rldRb) else $error("reload read");
endmodule // tmr_timer_system_properties

bind tmr_timer_system tmr_timer_system_properties
    tmr_timer_system_properties_inst (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .compareOut(compareOut), .irq(irq)
);

// ---- dv/tmr_pin_model.sv ----
// Far-side sources of count, gate, reload and capture pins
`timescale 1ns/1ps
module tmr_pin_model (
    // Clock
    input wire        core_clk,
    // Pins, idle high
    output reg [10:0] pinLvl
);
    initial pinLvl = 11'h7FF;
    // Falls held low five cycles, high for gap plus one cycles
    task fall(input int idx, input int n, input int gap);
        repeat (n) begin
            @(posedge core_clk);
            pinLvl[idx] <= 1'b0;
            repeat (5) @(posedge core_clk);
            pinLvl[idx] <= 1'b1;
            repeat (gap) @(posedge core_clk);
        end
    endtask
    task level(input int idx, input logic lv);
        @(posedge core_clk);
        pinLvl[idx] <= lv;
    endtask
endmodule // tmr_pin_model

// ---- dv/tmr_timer_system_bench.sv ----
// Self-checking bench of the timer system
`timescale 1ns/1ps
`include "tmr_defines.vh"
module tmr_timer_system_bench;
    reg          core_clk;
    reg          rst;
    reg  [4:0]   regAddr;
    reg  [7:0]   regWdata;
    reg          regWr;
    reg          regRd;
    wire [7:0]   regRdata;
    wire [3:0]   compareOut;
    wire         irq;
    wire [10:0]  pins;
    int          miscompares = 0;
    int          testsRun = 0;
    int          cyc = 0;
    int          k;
    int          i;
    logic [31:0] seed = 32'h0001_6E07;
    logic [15:0] v;
    logic [15:0] w;
    logic [7:0]  d;
    logic [4:0]  ta;

    tmr_timer_system tmr_timer_system_inst (
        .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata),
        .firstTimerCountInput(pins[`TMR_PIN_CNT0]),
        .secondTimerCountInput(pins[`TMR_PIN_CNT1]),
        .firstTimerGate(pins[`TMR_PIN_GATE0]),
        .secondTimerGate(pins[`TMR_PIN_GATE1]),
        .thirdTimerCountInput(pins[`TMR_PIN_CNT2]),
        .thirdTimerGate(pins[`TMR_PIN_GATE2]),
        .thirdTimerReloadTriggerInput(pins[`TMR_PIN_RLD2]),
        .captureIn(pins[10:7]), .compareOut(compareOut), .irq(irq)
    );
    tmr_pin_model tmr_pin_model_inst (
        .core_clk(core_clk),
        .pinLvl(pins)
    );

    function automatic logic [31:0] xr();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Next count value for a timer mode
    function automatic logic [15:0] nxt(input logic [15:0] x, input int md,
                                        input logic [15:0] rl);
        case (md)
            0: nxt = (x[4:0] == 5'h1F) ? {x[15:8] + 8'h01, x[7:5], 5'h00}
                                       : x + 16'h0001;
            2: nxt = (x[7:0] == 8'hFF) ? {x[15:8], x[15:8]} : x + 16'h0001;
            3: nxt = {x[15:8] + 8'h01, x[7:0] + 8'h01};
            default: nxt = (x == 16'hFFFF) ? rl : x + 16'h0001;
        endcase
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic near(input logic [15:0] got, input logic [15:0] s,
                        input int n, input int md, input logic [15:0] rl);
        logic [15:0] x;
        int hit;
        x = s;
        hit = 0;
        for (int j = 0; j <= n + 3; j++) begin
            if (j >= n - 3 && x === got) hit = 1;
            x = nxt(x, md, rl);
        end
        testsRun++;
        if (hit == 0) begin
            miscompares++;
            $display("unexpected at %0t: count %h", $time, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] dt);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= dt;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] dt);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 dt = regRdata;
    endtask
    task automatic wr16(input logic [4:0] a, input logic [15:0] s);
        wr(a, s[7:0]);
        wr(a + 5'h01, s[15:8]);
    endtask
    task automatic rd16(input logic [4:0] a, output logic [15:0] r);
        logic [7:0] h;
        logic [7:0] l;
        rd(a + 5'h01, h);
        rd(a, l);
        r = {h, l};
    endtask
    task automatic run(input logic [7:0] c, input int n);
        wr(`TMR_OFF_CTRL, c);
        repeat (n) @(posedge core_clk);
        wr(`TMR_OFF_CTRL, 8'h00);
    endtask
    task automatic flag(input int b);
        rd(`TMR_OFF_STATUS, d);
        chk({15'h0000, d[b]}, 16'h0001);
        wr(`TMR_OFF_MASK, 8'(1 << b));
        #1 chk({15'h0000, irq}, 16'h0001);
        wr(`TMR_OFF_STATUS, 8'(1 << b));
        #1 chk({15'h0000, irq}, 16'h0000);
        wr(`TMR_OFF_MASK, 8'h00);
    endtask
    task automatic tmode(input logic [7:0] m, input logic [4:0] a,
                         input logic [15:0] s, input logic [7:0] c,
                         input int md, input int b);
        wr(`TMR_OFF_MODE01, m);
        wr16(a, s);
        run(c, 12);
        rd16(a, v);
        near(v, s, 14, md, 16'h0000);
        flag(b);
    endtask
    task automatic t2run(input logic [7:0] c, input int n,
                         input logic [15:0] s, input int e);
        wr16(`TMR_OFF_T2LO, s);
        run(c, n);
        rd16(`TMR_OFF_T2LO, v);
        near(v, s, e, 1, w);
    endtask
    task automatic testDone;
        $display("compares %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            testDone;
        end
    end

    initial begin
        rst = 1'b1;
        regAddr = 5'h00;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 32; i++) begin
            rd(5'(i), d);
            chk({8'h00, d}, 16'h0000);
        end
        w = 16'(xr());
        wr(`TMR_OFF_MASK, w[7:0]);
        rd(`TMR_OFF_MASK, d);
        chk({8'h00, d}, {8'h00, w[7:0]});
        wr(`TMR_OFF_MASK, 8'h00);
        wr16(`TMR_OFF_RLDLO, w);
        rd16(`TMR_OFF_RLDLO, v);
        chk(v, w);
        wr(`TMR_OFF_CMPOUT, 8'hFF);
        rd(`TMR_OFF_CMPOUT, d);
        chk({8'h00, d}, 16'h0000);
        tmode(8'h00, `TMR_OFF_T0LO, 16'hFFFE, 8'h01, 0, 0);
        tmode(8'h01, `TMR_OFF_T0LO, 16'hFFF8, 8'h01, 1, 0);
        tmode(8'h20, `TMR_OFF_T1LO, 16'hC0FC, 8'h02, 2, 1);
        tmode(8'h03, `TMR_OFF_T0LO, 16'hF800, 8'h05, 3, 1);
        for (i = 0; i < 2; i++) begin
            k = 1 + int'(xr() % 6);
            ta = `TMR_OFF_T0LO + 5'(2 * i);
            wr(`TMR_OFF_MODE01, i ? 8'h50 : 8'h05);
            wr16(ta, 16'h0000);
            wr(`TMR_OFF_CTRL, 8'(1 << i));
            tmr_pin_model_inst.fall(`TMR_PIN_CNT0 + i, k, 3 + 4 * i);
            repeat (8) @(posedge core_clk);
            wr(`TMR_OFF_CTRL, 8'h00);
            rd16(ta, v);
            chk(v, 16'(k));
            tmr_pin_model_inst.level(`TMR_PIN_GATE0 + i, 1'b0);
            wr(`TMR_OFF_MODE01, i ? 8'h90 : 8'h09);
            wr16(ta, 16'h0000);
            run(8'(1 << i), 12);
            rd16(ta, v);
            chk(v, 16'h0000);
            tmr_pin_model_inst.level(`TMR_PIN_GATE0 + i, 1'b1);
            repeat (6) @(posedge core_clk);
            run(8'(1 << i), 12);
            rd16(ta, v);
            near(v, 16'h0000, 14, 1, 16'h0000);
        end
        t2run(8'h08, 20, 16'h0000, 22);
        t2run(8'h28, 40, 16'h0000, 21);
        w = {1'b0, 15'(xr())};
        wr16(`TMR_OFF_RLDLO, w);
        t2run(8'h88, 12, 16'hFFF8, 14);
        flag(2);
        k = 1 + int'(xr() % 6);
        wr16(`TMR_OFF_T2LO, 16'h0000);
        wr(`TMR_OFF_CTRL, 8'h10);
        tmr_pin_model_inst.fall(`TMR_PIN_CNT2, k, 3);
        repeat (8) @(posedge core_clk);
        wr(`TMR_OFF_CTRL, 8'h00);
        rd16(`TMR_OFF_T2LO, v);
        chk(v, 16'(k));
        tmr_pin_model_inst.level(`TMR_PIN_GATE2, 1'b0);
        wr16(`TMR_OFF_T2LO, 16'h0000);
        run(8'h18, 12);
        rd16(`TMR_OFF_T2LO, v);
        chk(v, 16'h0000);
        tmr_pin_model_inst.level(`TMR_PIN_GATE2, 1'b1);
        repeat (6) @(posedge core_clk);
        t2run(8'h18, 12, 16'h0000, 14);
        w = 16'(xr());
        wr16(`TMR_OFF_RLDLO, w);
        wr16(`TMR_OFF_T2LO, 16'h0000);
        wr(`TMR_OFF_CTRL, 8'hC0);
        tmr_pin_model_inst.fall(`TMR_PIN_RLD2, 1, 3);
        repeat (6) @(posedge core_clk);
        wr(`TMR_OFF_CTRL, 8'h00);
        rd16(`TMR_OFF_T2LO, v);
        chk(v, w);
        flag(3);
        w = 16'h0008 + 16'(xr() % 24);
        wr16(`TMR_OFF_CC0LO, w);
        wr16(`TMR_OFF_CC0LO + 5'h02, 16'h8000);
        wr(`TMR_OFF_CCMODE, 8'h05);
        t2run(8'h08, 40, 16'h0000, 42);
        chk({12'h000, compareOut}, 16'h0001);
        rd(`TMR_OFF_CMPOUT, d);
        chk({8'h00, d}, 16'h0001);
        wr(`TMR_OFF_CCMODE, 8'h00);
        flag(4);
        w = 16'(xr());
        wr16(`TMR_OFF_T2LO, w);
        wr(`TMR_OFF_CCMODE, 8'hE0);
        tmr_pin_model_inst.fall(`TMR_PIN_CAP_LSB + 2, 1, 3);
        repeat (6) @(posedge core_clk);
        rd16(`TMR_OFF_CC0LO + 5'h04, v);
        chk(v, w);
        wr(`TMR_OFF_CC0LO + 5'h06, 8'h55);
        rd16(`TMR_OFF_CC0LO + 5'h06, v);
        chk(v, w);
        flag(6);
        flag(7);
        testDone;
    end
endmodule // tmr_timer_system_bench
